// File: rtl/sps_pkg.sv
/*
  Shared constants for the serial protocol status block: register offsets,
  field positions, reset values, payload size codes and footer widths.
  Assumes it is compiled before every other file of the block.
*/
`default_nettype none

package sps_pkg;

  // ==========================================================
  // Register map (control space 0, word addresses)
  localparam logic [15:0] SPS_ADDR_FLAGS  = 16'h0008;
  localparam logic [15:0] SPS_ADDR_LEVELS = 16'h000b;

  // ==========================================================
  // Flag register field positions
  localparam int SPS_BIT_TX_PROTO = 0;
  localparam int SPS_BIT_TX_OVF   = 1;
  localparam int SPS_BIT_TX_UNF   = 2;
  localparam int SPS_BIT_RX_OVF   = 3;
  localparam int SPS_BIT_FRAMING  = 4;
  localparam int SPS_BIT_HDR_PAR  = 5;
  localparam int SPS_BIT_RSTDN  = 6;
  localparam int SPS_BIT_PHYIRQ = 7;
  localparam int SPS_BIT_TSCAP  = 8;
  localparam int SPS_ERR_W      = 6;

  // ==========================================================
  // Level register field positions and reset values, plus the flag register reset value
  localparam int         SPS_CREDIT_LSB    = 8;
  localparam int         SPS_READY_LSB     = 0;
  localparam int         SPS_CNT_W         = 8;
  localparam logic [7:0] SPS_CREDIT_RESET  = 8'h3c;
  localparam logic [7:0] SPS_READY_RESET   = 8'h00;
  localparam logic [31:0] SPS_FLAGS_RESET  = 32'h0000_0040;
  localparam logic [31:0] SPS_LEVELS_RESET = 32'h0000_3c00;

  // ==========================================================
  // Buffers and chunk framing
  localparam int          SPS_BUF_BYTES   = 4096;
  localparam logic [2:0]  SPS_PSIZE_8     = 3'h3;
  localparam logic [2:0]  SPS_PSIZE_16    = 3'h4;
  localparam logic [2:0]  SPS_PSIZE_32    = 3'h5;
  localparam logic [2:0]  SPS_PSIZE_64    = 3'h6;
  localparam logic [15:0] SPS_HDR_BITS    = 16'h0020;
  localparam int          SPS_FTR_FIELD_W = 5;

  // Transmit frame tracking, one-hot
  typedef enum logic [1:0]
  {
    SPS_FRM_IDLE = 2'b01,
    SPS_FRM_OPEN = 2'b10
  } sps_frm_t;

endpackage

`default_nettype wire

// File: rtl/sps_pin_sync.sv
/*
  Two-flop synchroniser bank with edge detection on the second stage.
  Assumes its inputs are pins asynchronous to sys_clk; nothing reads the
  first stage except the second.
*/
`default_nettype none

module sps_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync,
  output logic      [W-1:0] pin_rise,
  output logic      [W-1:0] pin_fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
  } sps_sync_t;

  sps_sync_t s_r;
  sps_sync_t s_nxt;

  // ==========================================================
  // Stage chain; resets high so an idle chip select looks idle
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = pin_in;
    s_nxt.sync = s_r.meta;
    s_nxt.last = s_r.sync;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      s_r <= '{meta: '1, sync: '1, last: '1};
    else
      s_r <= s_nxt;
  end

  // Edges per bit, from second and third stages only
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_edge
      assign pin_rise[g] = s_r.sync[g] & ~s_r.last[g];
      assign pin_fall[g] = ~s_r.sync[g] & s_r.last[g];
    end
  endgenerate

  assign pin_sync = s_r.sync;

endmodule

`default_nettype wire

// File: rtl/sps_status.sv
/*
  Serial protocol flag register and buffer chunk level register of the
  MAC-PHY host interface, with interrupt and footer status generation.
  Assumes a control decoder on sys_clk issues register accesses and chunk
  header events; chip select and serial clock arrive as raw pins.
*/
// What this block does
// RULE1 - Bit 7 mirrors the PHY interrupt request; clears only when PHY acknowledges.
// RULE2 - Bit 6 reset-done flag sets when reset completes; reads 1 after reset.
// RULE3 - Reset-done flag drives the low interrupt output regardless of masks.
// RULE4 - Reset-done flag sets the footer extended-status bit in every receive chunk.
// RULE5 - Host writes 1 to clear reset-done; writing 0 leaves it.
// RULE6 - Bit 5 latches on a header parity failure until cleared.
// RULE7 - Bit 4 sets when chip select ends a chunk or command early.
// RULE8 - Bit 3 sets when a network frame is dropped for lack of receive space.
// RULE9 - Bit 2 sets on transmit underflow, only possible in cut-through mode.
// RULE10 - Bit 1 sets when the transmit buffer overflows and data is lost.
// RULE11 - Bit 0 sets on a data-valid chunk without an open frame.
// RULE12 - Bit 0 sets on a second start-valid before the frame closes.
// RULE13 - Bit 0 sets on end-valid without an earlier start-valid.
// RULE14 - Bit 0 sets when start word or end byte offset exceeds payload size.
// RULE15 - Bits 15:8 report free transmit chunks; reset value 0x3C.
// RULE16 - Writing a transmit chunk with zero credits counts as overflow.
// RULE17 - Footer carries the low five bits of the transmit credit count.
// RULE18 - Bits 7:0 report receive chunks ready for the host; reset 0.
// RULE19 - Footer carries the low five bits of receive chunks ready.
// RULE20 - Separate 4 kB buffers; chunk counts follow their occupancy.
// RULE21 - Maskable flags drive interrupt and extended status only while unmasked.
// RULE22 - Payload size code 3..6 means 8, 16, 32, 64 bytes; default 64.
// RULE23 - Cut-through enable is the only mode where underflow may occur.
// RULE24 - Error flags hold until the host writes 1; writing 0 does nothing.
// RULE25 - Bit 8 always reads 0 and ignores writes.
`default_nettype none

module sps_status
  import sps_pkg::*;
#(
  parameter int                TX_CHUNKS = 60,
  parameter int                RX_CHUNKS = 64,
  parameter logic [SPS_CNT_W-1:0] CREDIT_RST = sps_pkg::SPS_CREDIT_RESET
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // Raw serial pins
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_sclk,
  // Register port from the control decoder
  input  wire logic [15:0]           reg_addr,
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic [31:0]           reg_wdata,
  output logic      [31:0]           reg_rdata,
  output logic                       reg_rvalid,
  // Configuration from the neighbouring registers
  input  wire logic [2:0]            chunk_payload_size,
  input  wire logic                  tx_cut_through_en,
  input  wire logic [7:0]            irq_mask,
  // Transaction shape from the decoder
  input  wire logic                  xact_is_ctrl,
  input  wire logic [15:0]           ctrl_xact_bits,
  // Events
  input  wire logic                  phy_irq_req,
  input  wire logic                  hdr_parity_fail,
  input  wire logic                  rx_frame_drop,
  input  wire logic                  tx_line_starved,
  input  wire logic                  tx_hdr_valid,
  input  wire logic                  chunk_data_valid,
  input  wire logic                  frame_start_valid,
  input  wire logic                  frame_end_valid,
  input  wire logic [3:0]            start_word_offset,
  input  wire logic [5:0]            end_byte_offset,
  // Buffer occupancy events
  input  wire logic                  tx_chunk_written,
  input  wire logic                  tx_chunk_drained,
  input  wire logic                  rx_chunk_filled,
  input  wire logic                  rx_chunk_read,
  // Status outputs
  output logic                       irq_out_n,
  output logic                       footer_extended_status,
  output logic [SPS_FTR_FIELD_W-1:0] footer_tx_credit,
  output logic [SPS_FTR_FIELD_W-1:0] footer_rx_chunks
);

  typedef struct packed {
    logic                 phy_pend;
    logic                 reset_done;
    logic [SPS_ERR_W-1:0] err;
    logic [SPS_CNT_W-1:0] tx_credit;
    logic [SPS_CNT_W-1:0] rx_ready;
    sps_frm_t             frm;
    logic [15:0]          bit_pos;
    logic [31:0]          rdata;
    logic                 rvalid;
    logic                 irq_n;
    logic                 ext_stat;
  } sps_state_t;

  sps_state_t st_r;
  sps_state_t st_nxt;

  logic [1:0] pin_sync;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  // ==========================================================
  // Payload bytes for a size code; unknown codes fall back to 64
  function automatic logic [15:0] payload_bytes(input logic [2:0] size_code);
    logic [15:0] b;
    case (size_code)
      SPS_PSIZE_8:  b = 16'h0008; // see RULE22
      SPS_PSIZE_16: b = 16'h0010;
      SPS_PSIZE_32: b = 16'h0020;
      default:    b = 16'h0040;
    endcase
    return b;
  endfunction

  // ==========================================================
  // Pin synchronisers: bit 1 chip select, bit 0 serial clock
  sps_pin_sync #(
    .W (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .pin_in   ({spi_cs_n, spi_sclk}),
    .pin_sync (pin_sync),
    .pin_rise (pin_rise),
    .pin_fall ()
  );

  logic        cs_active;
  logic        sclk_rise;
  logic        cs_end;
  logic [15:0] pay_bytes;
  logic [15:0] unit_bits;
  logic        wr_flags;
  logic        rd_hit;
  logic [SPS_ERR_W-1:0] err_set;
  logic [SPS_ERR_W-1:0] err_clr;
  logic        offs_bad;
  logic        seq_bad;
  logic        tx_ovf;
  logic [31:0] flags_word;
  logic [31:0] levels_word;

  assign cs_active = ~pin_sync[1];
  assign sclk_rise = pin_rise[0] & cs_active;
  assign cs_end    = pin_rise[1];
  assign pay_bytes = payload_bytes(chunk_payload_size);
  // A chunk is a 32-bit header or footer plus the payload
  assign unit_bits = xact_is_ctrl ? ctrl_xact_bits : (SPS_HDR_BITS + {pay_bytes[12:0], 3'b000});
  assign wr_flags  = reg_wr_en & (reg_addr == SPS_ADDR_FLAGS);
  assign rd_hit    = reg_rd_en;

  // ==========================================================
  // Transmit chunk header checks
  assign offs_bad = tx_hdr_valid & chunk_data_valid &
                    ((frame_start_valid & ({10'h000, start_word_offset, 2'b00} >= pay_bytes)) |
                     (frame_end_valid & ({10'h000, end_byte_offset} >= pay_bytes))); // see RULE14
  always_comb
  begin
    seq_bad = 1'b0;
    if (tx_hdr_valid && chunk_data_valid)
    begin
      if (st_r.frm == SPS_FRM_IDLE)
        seq_bad = ~frame_start_valid; // see RULE11 see RULE13
      else
        seq_bad = frame_start_valid & ~frame_end_valid; // see RULE12
    end
  end

  // Writing with no credit left is an overflow, never a count wrap
  assign tx_ovf = tx_chunk_written & (st_r.tx_credit == '0); // see RULE16

  // ==========================================================
  // Hardware set terms and host write-one-to-clear terms
  always_comb
  begin
    err_set                = '0;
    err_set[SPS_BIT_HDR_PAR]  = hdr_parity_fail; // see RULE6
    err_set[SPS_BIT_FRAMING]  = cs_end & (st_r.bit_pos != 16'h0000); // see RULE7
    err_set[SPS_BIT_RX_OVF]   = rx_frame_drop; // see RULE8
    err_set[SPS_BIT_TX_UNF]   = tx_line_starved & tx_cut_through_en; // see RULE9 see RULE23
    err_set[SPS_BIT_TX_OVF]   = tx_ovf; // see RULE10
    err_set[SPS_BIT_TX_PROTO] = offs_bad | seq_bad;
    err_clr                = wr_flags ? reg_wdata[SPS_ERR_W-1:0] : '0;
  end

  assign flags_word  = {23'h000000, 1'b0, st_r.phy_pend, st_r.reset_done, st_r.err}; // see RULE25
  assign levels_word = {16'h0000, st_r.tx_credit, st_r.rx_ready}; // see RULE15 see RULE18

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;

    // Level mirror, no latching; the PHY owns the acknowledge
    st_nxt.phy_pend = phy_irq_req; // see RULE1

    // Clear on a written one only; no hardware set after reset
    if (wr_flags && reg_wdata[SPS_BIT_RSTDN])
      st_nxt.reset_done = 1'b0; // see RULE5

    // Set beats clear so an event in the clearing cycle survives
    st_nxt.err = (st_r.err & ~err_clr) | err_set; // see RULE24

    // Credits: both events in one cycle cancel out, except at zero credit where the write overflows and the drain adds one
    if (tx_chunk_written && !tx_ovf && !tx_chunk_drained)
      st_nxt.tx_credit = st_r.tx_credit - 8'h01; // see RULE20
    else if (tx_chunk_drained && !(tx_chunk_written && !tx_ovf) &&
             (32'(st_r.tx_credit) < TX_CHUNKS))
      st_nxt.tx_credit = st_r.tx_credit + 8'h01;

    if (rx_chunk_filled && !rx_chunk_read && (32'(st_r.rx_ready) < RX_CHUNKS))
      st_nxt.rx_ready = st_r.rx_ready + 8'h01; // see RULE20
    else if (rx_chunk_read && !rx_chunk_filled && (st_r.rx_ready != '0))
      st_nxt.rx_ready = st_r.rx_ready - 8'h01;

    // Frame tracking follows each accepted data chunk
    if (tx_hdr_valid && chunk_data_valid)
    begin
      case (st_r.frm)
        SPS_FRM_IDLE:
          if (frame_start_valid && !frame_end_valid)
            st_nxt.frm = SPS_FRM_OPEN;
        SPS_FRM_OPEN:
          if (frame_end_valid && !frame_start_valid)
            st_nxt.frm = SPS_FRM_IDLE;
        default:
          st_nxt.frm = SPS_FRM_IDLE;
      endcase
    end

    // Bit position inside the current chunk or command
    if (cs_end)
      st_nxt.bit_pos = 16'h0000;
    else if (sclk_rise)
      st_nxt.bit_pos = (st_r.bit_pos >= unit_bits - 16'h0001) ? 16'h0000 : st_r.bit_pos + 16'h0001;

    // Reads answer one cycle later; unmapped words read zero
    st_nxt.rvalid = rd_hit;
    if (rd_hit)
    begin
      case (reg_addr)
        SPS_ADDR_FLAGS:  st_nxt.rdata = flags_word;
        SPS_ADDR_LEVELS: st_nxt.rdata = levels_word;
        default:         st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Mask bit 6 is ignored: reset-done cannot be masked
    st_nxt.ext_stat = st_nxt.reset_done |
                      (|({st_nxt.phy_pend, st_nxt.err} & ~{irq_mask[7], irq_mask[5:0]})); // see RULE21 see RULE4
    st_nxt.irq_n    = ~st_nxt.ext_stat; // see RULE3
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st_r            <= '0;
      st_r.reset_done <= 1'b1; // see RULE2
      st_r.tx_credit  <= CREDIT_RST; // see RULE15
      st_r.rx_ready   <= SPS_READY_RESET; // see RULE18
      st_r.frm        <= SPS_FRM_IDLE;
      st_r.irq_n      <= 1'b0;
      st_r.ext_stat   <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign reg_rdata              = st_r.rdata;
  assign reg_rvalid             = st_r.rvalid;
  assign irq_out_n              = st_r.irq_n;
  assign footer_extended_status = st_r.ext_stat;
  assign footer_tx_credit       = st_r.tx_credit[SPS_FTR_FIELD_W-1:0]; // see RULE17
  assign footer_rx_chunks       = st_r.rx_ready[SPS_FTR_FIELD_W-1:0]; // see RULE19

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // PHY bit trails its request by exactly one register stage, both ways
  a_phy_mirror_lag: assert property (1'b1 |=> st_r.phy_pend == $past(phy_irq_req)) // see RULE1
    else $error("phy interrupt not mirrored");

  // Interrupt and reset-done leave the same register edge, so the interrupt is low in every cycle reset-done is set
  a_rstdn_irq_low: assert property (st_r.reset_done |-> !irq_out_n) // see RULE3
    else $error("reset done did not hold interrupt low");

  a_rstdn_w1c: assert property (wr_flags && reg_wdata[SPS_BIT_RSTDN] |=> !st_r.reset_done) // see RULE5
    else $error("reset done not cleared by write one");

  a_rstdn_w0_keep: assert property (wr_flags && !reg_wdata[SPS_BIT_RSTDN] && st_r.reset_done
                                    |=> st_r.reset_done) // see RULE5
    else $error("reset done lost on write zero");

  a_hdrpar_sticky: assert property (hdr_parity_fail |=> st_r.err[SPS_BIT_HDR_PAR] [*2]
                                    or (st_r.err[SPS_BIT_HDR_PAR] ##1 $past(err_clr[SPS_BIT_HDR_PAR]))) // see RULE6
    else $error("header error not latched");

  a_txovf_credit: assert property (tx_chunk_written && st_r.tx_credit == '0 && !tx_chunk_drained
                                   |=> st_r.err[SPS_BIT_TX_OVF] && st_r.tx_credit == '0) // see RULE16
    else $error("write at zero credit not flagged");

  a_unf_gate: assert property (!tx_cut_through_en && !st_r.err[SPS_BIT_TX_UNF]
                               |=> !st_r.err[SPS_BIT_TX_UNF]) // see RULE9
    else $error("underflow flagged outside cut-through");

  a_proto_nostart: assert property (tx_hdr_valid && chunk_data_valid && !frame_start_valid &&
                                    st_r.frm == SPS_FRM_IDLE |=> st_r.err[SPS_BIT_TX_PROTO]) // see RULE11
    else $error("data without start not flagged");

  a_framing_early: assert property (cs_end && st_r.bit_pos != 16'h0000 |=> st_r.err[SPS_BIT_FRAMING]) // see RULE7
    else $error("early chip select end not flagged");

  a_levels_read: assert property (reg_rd_en && reg_addr == SPS_ADDR_LEVELS
                                  |=> reg_rvalid && reg_rdata == $past(levels_word)) // see RULE15
    else $error("level register read wrong");

  a_tscap_zero: assert property (reg_rvalid && $past(reg_addr) == SPS_ADDR_FLAGS
                                 |-> reg_rdata[SPS_BIT_TSCAP] == 1'b0) // see RULE25
    else $error("timestamp bit read nonzero");

  a_mask_gate: assert property (!st_r.reset_done && (&{irq_mask[7], irq_mask[5:0]}) ##1
                                (&{irq_mask[7], irq_mask[5:0]}) && !st_r.reset_done |-> irq_out_n) // see RULE21
    else $error("masked flag raised interrupt");

  c_rstdn_cleared: cover property (st_r.reset_done ##1 !st_r.reset_done);
  c_frame_open_close: cover property (st_r.frm == SPS_FRM_OPEN ##[1:40] st_r.frm == SPS_FRM_IDLE);
  c_credit_zero: cover property (st_r.tx_credit == '0 && tx_chunk_written);
  c_framing_seen: cover property ($rose(st_r.err[SPS_BIT_FRAMING]));

endmodule

`default_nettype wire

// File: dv/sps_host_model.sv
/*
  Host side of the serial link: drives chip select and serial clock pins.
  Assumes the bench calls xfer between register accesses; the pins are
  asynchronous to sys_clk and the serial clock stands low outside frames.
*/
`default_nettype none

module sps_host_model (
  output var logic spi_cs_n,
  output var logic spi_sclk
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Idle pin levels
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
  end

  // ==========================================================
  // One selected frame of n serial clock rises at a 125 ns period
  task automatic xfer(input int n);
    spi_cs_n = 1'b0;
    #100;
    repeat (n)
    begin
      #62.5;
      spi_sclk = 1'b1;
      #62.5;
      spi_sclk = 1'b0;
    end
    #100;
    spi_cs_n = 1'b1; // Short n ends the unit early
    #400;
  endtask
endmodule

`default_nettype wire

// File: dv/sps_status_tb_top.sv
/*
  Self-checking bench for the flag and level registers of sps_status.
  Assumes sps_pkg is compiled first and the host model drives the pins.
*/
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module sps_status_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sps_pkg::*;

  logic        sys_clk, rstn, reg_wr_en, reg_rd_en, reg_rvalid, tx_cut_through_en, xact_is_ctrl, phy_irq_req;
  logic        chunk_data_valid, frame_start_valid, frame_end_valid, irq_out_n, footer_extended_status;
  logic [15:0] reg_addr, ctrl_xact_bits;
  logic [31:0] reg_wdata, reg_rdata, rd_data;
  logic [2:0]  chunk_payload_size;
  logic [7:0]  irq_mask, evt;
  logic [3:0]  start_word_offset;
  logic [5:0]  end_byte_offset;
  logic [4:0]  footer_tx_credit, footer_rx_chunks;
  wire         spi_cs_n, spi_sclk;
  int          errors, n_checks, cycles, exp_credit, exp_ready, n, k, p, cap;
  int          seed = 93;

  sps_host_model u_host (.spi_cs_n, .spi_sclk);

  sps_status DUT (.sys_clk, .rstn, .spi_cs_n, .spi_sclk, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata, .reg_rvalid, .chunk_payload_size, .tx_cut_through_en, .irq_mask, .xact_is_ctrl,
    .ctrl_xact_bits, .phy_irq_req, .hdr_parity_fail(evt[0]), .rx_frame_drop(evt[1]), .tx_line_starved(evt[2]),
    .tx_hdr_valid(evt[7]), .chunk_data_valid, .frame_start_valid, .frame_end_valid, .start_word_offset,
    .end_byte_offset, .tx_chunk_written(evt[3]), .tx_chunk_drained(evt[4]), .rx_chunk_filled(evt[5]),
    .rx_chunk_read(evt[6]), .irq_out_n, .footer_extended_status, .footer_tx_credit, .footer_rx_chunks);

  // ==========================================================
  // Clock and hang guard; the ceiling is well above the expected run
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      $display("[FAIL] run_length expected done seen hang");
      stop_test();
    end
  end

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] lv(input int t, input int r);
    return {16'h0, 8'(t), 8'(r)};
  endfunction
  function automatic int pbytes(input int code);
    return 8 << (code - 3);
  endfunction

  // ==========================================================
  // Register port and event drivers, launched at the rising edge except the hdr fields, which are set before the pulse
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    #1;
  endtask
  task automatic chk_rd(input string nm, input logic [15:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    rd_data = reg_rdata;
    `CHK("read_valid", 1'b1, reg_rvalid)
    `CHK(nm, e, rd_data)
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge sys_clk);
    evt <= m;
    @(posedge sys_clk);
    evt <= 8'h00;
    #1;
  endtask
  // Checks the flags, then clears them all; bit 8 must swallow the write
  task automatic flags_clr(input logic [31:0] e);
    chk_rd("flags", SPS_ADDR_FLAGS, e);
    wr(SPS_ADDR_FLAGS, 32'h1ff);
  endtask
  task automatic hdr(input logic dval, input logic sval, input logic evl, input int so, input int eo);
    chunk_data_valid  <= dval;
    frame_start_valid <= sval;
    frame_end_valid   <= evl;
    start_word_offset <= 4'(so);
    end_byte_offset   <= 6'(eo);
    pulse(8'h80);
  endtask
  task automatic chk_lv();
    chk_rd("levels", SPS_ADDR_LEVELS, lv(exp_credit, exp_ready));
    `CHK("footer_tx", 5'(exp_credit), footer_tx_credit)
    `CHK("footer_rx", 5'(exp_ready), footer_rx_chunks)
  endtask
  // Latched error event: masked, unmasked, write 0, write 1
  task automatic err_case(input int i, input int b);
    pulse(8'(1 << i));
    `CHK("irq_masked", 1'b1, irq_out_n)
    chk_rd("flag_set", SPS_ADDR_FLAGS, 32'(1 << b));
    @(posedge sys_clk);
    irq_mask <= ~8'(1 << b);
    @(posedge sys_clk);
    #1;
    `CHK("irq_unmasked", 1'b0, irq_out_n)
    `CHK("ext_unmasked", 1'b1, footer_extended_status)
    wr(SPS_ADDR_FLAGS, 32'h0);
    chk_rd("flag_held", SPS_ADDR_FLAGS, 32'(1 << b));
    wr(SPS_ADDR_FLAGS, 32'(1 << b));
    `CHK("irq_cleared", 1'b1, irq_out_n)
    irq_mask <= 8'hff;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {rstn, reg_wr_en, reg_rd_en, tx_cut_through_en, xact_is_ctrl, phy_irq_req} = '0;
    {chunk_data_valid, frame_start_valid, frame_end_valid, start_word_offset, end_byte_offset} = '0;
    {reg_addr, reg_wdata, evt} = '0;
    ctrl_xact_bits = 16'h0010;
    chunk_payload_size = SPS_PSIZE_64;
    irq_mask = 8'hff;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    exp_credit = 60;
    exp_ready = 0;
    // Receive buffer holds this many 64-byte chunks at most
    cap = SPS_BUF_BYTES / pbytes(SPS_PSIZE_64);
    `CHK("irq_reset", 1'b0, irq_out_n)
    `CHK("ext_reset", 1'b1, footer_extended_status)
    chk_lv();
    wr(SPS_ADDR_FLAGS, 32'h0);
    chk_rd("flags_reset", SPS_ADDR_FLAGS, SPS_FLAGS_RESET);
    wr(SPS_ADDR_FLAGS, 32'h40);
    `CHK("irq_after_clear", 1'b1, irq_out_n)
    chk_rd("flags_cleared", SPS_ADDR_FLAGS, 32'h0);
    wr(SPS_ADDR_FLAGS, 32'h100);
    chk_rd("bit8", SPS_ADDR_FLAGS, 32'h0);
    chk_rd("unmapped", 16'h0003, 32'h0);
    wr(SPS_ADDR_LEVELS, 32'hffff);
    chk_lv();
    $display("test registers done");
    // Header parity, receive overflow and underflow flags, each with its mask
    err_case(0, SPS_BIT_HDR_PAR);
    err_case(1, SPS_BIT_RX_OVF);
    pulse(8'h04);
    flags_clr(32'h0);
    tx_cut_through_en <= 1'b1;
    err_case(2, SPS_BIT_TX_UNF);
    $display("test error flags done");
    // PHY interrupt mirror
    phy_irq_req <= 1'b1;
    irq_mask <= 8'h7f;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("irq_phy", 1'b0, irq_out_n)
    wr(SPS_ADDR_FLAGS, 32'h80);
    chk_rd("phy_held", SPS_ADDR_FLAGS, 32'h80);
    phy_irq_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_rd("phy_gone", SPS_ADDR_FLAGS, 32'h0);
    irq_mask <= 8'hff;
    $display("test phy done");
    // Transmit chunk protocol
    hdr(1, 0, 0, 0, 0);
    flags_clr(32'h1);
    hdr(1, 1, 0, 0, 0);
    hdr(1, 0, 0, 0, 0);
    hdr(0, 0, 1, 0, 0);
    hdr(1, 0, 1, 0, 0);
    flags_clr(32'h0);
    hdr(1, 0, 1, 0, 0);
    flags_clr(32'h1);
    hdr(1, 1, 0, 0, 0);
    hdr(1, 1, 0, 0, 0);
    hdr(1, 0, 1, 0, 0);
    flags_clr(32'h1);
    for (int c = 3; c <= 6; c++)
    begin
      p = pbytes(c);
      chunk_payload_size <= 3'(c);
      hdr(1, 1, 1, (p / 4) - 1, (p > 63) ? 63 : p - 1);
      flags_clr(32'h0);
      if (c < 6)
      begin
        hdr(1, 1, 1, 0, p);
        flags_clr(32'h1);
        hdr(1, 1, 1, p / 4, 0);
        flags_clr(32'h1);
      end
    end
    $display("test tx protocol done");
    // Transmit credits: cap, run down to zero, overflow, paired events
    pulse(8'h08 << 1);
    chk_lv();
    repeat (60) pulse(8'h08);
    exp_credit = 0;
    chk_lv();
    pulse(8'h08);
    flags_clr(32'h2);
    chk_lv();
    // A drain frees one chunk first, so the paired write and drain that follow cancel
    pulse(8'h10);
    pulse(8'h18);
    exp_credit = 1;
    chk_lv();
    // Receive chunks at random, fills may reach the cap and reads may run past empty
    for (int r = 0; r < 4; r++)
    begin
      n = 1 + ($unsigned($random(seed)) % 20);
      k = $unsigned($random(seed)) % (exp_ready + n + 3);
      repeat (n) pulse(8'h20);
      exp_ready = (exp_ready + n > cap) ? cap : exp_ready + n;
      chk_lv();
      repeat (k) pulse(8'h40);
      exp_ready = (k > exp_ready) ? 0 : exp_ready - k;
      chk_lv();
    end
    $display("test levels done");
    // Framing: whole data chunk, short data chunk, whole control command
    u_host.xfer(32 + 8 * 64);
    flags_clr(32'h0);
    u_host.xfer(100);
    flags_clr(32'h10);
    xact_is_ctrl <= 1'b1;
    u_host.xfer(16);
    flags_clr(32'h0);
    $display("test framing done");
    // Mid-run reset must bring every flag and count back to its reset value
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    exp_credit = 60;
    exp_ready = 0;
    `CHK("irq_rerun", 1'b0, irq_out_n)
    chk_lv();
    chk_rd("flags_rerun", SPS_ADDR_FLAGS, SPS_FLAGS_RESET);
    $display("test reset done");
    stop_test();
  end
endmodule

`default_nettype wire
